// [phc_map.svh]
/*
 Offsets, field positions, reset words and fixed codes of the bank.
 Assumes inclusion by bare name from the package and the bank.
*/
`ifndef PHC_MAP_SVH
`define PHC_MAP_SVH
// ----------------------------------------------------------------------
// Register addresses and storage slots.
// ----------------------------------------------------------------------
`define PHC_ADDR_TRIP 5'h0E
`define PHC_ADDR_XTAL 5'h10
`define PHC_ADDR_LOOPF 5'h18
`define PHC_ADDR_RB 5'h1F
`define PHC_SLOT_TRIP 4'h0
`define PHC_SLOT_HOLD 4'h1
`define PHC_SLOT_LOOPF 4'h3
`define PHC_SLOT_DACDIV 4'h4
`define PHC_SLOT_L2PUMP 4'h5
`define PHC_SLOT_L1REF 4'h6
`define PHC_SLOT_LDIV 4'h7
`define PHC_SLOT_OSC 4'h8
`define PHC_SLOT_L2FB 4'h9
`define PHC_SLOT_RB 4'hA
// ----------------------------------------------------------------------
// Field positions (MSB and LSB, or a single bit).
// ----------------------------------------------------------------------
`define PHC_TOP10_MSB 31
`define PHC_TOP10_LSB 22
`define PHC_CNT14_MSB 19
`define PHC_CNT14_LSB 6
`define PHC_DIV18_MSB 22
`define PHC_DIV18_LSB 5
`define PHC_HITRIP_MSB 19
`define PHC_HITRIP_LSB 14
`define PHC_LOTRIP_MSB 11
`define PHC_LOTRIP_LSB 6
`define PHC_BIT5 5
`define PHC_MANEN_BIT 20
`define PHC_WIN1_MSB 7
`define PHC_WIN1_LSB 6
`define PHC_WIN2_MSB 31
`define PHC_WIN2_LSB 30
`define PHC_DOUBLER_BIT 29
`define PHC_PRE1_MSB 23
`define PHC_PRE1_LSB 22
`define PHC_PRE0_MSB 21
`define PHC_PRE0_LSB 20
`define PHC_L2R_MSB 31
`define PHC_L2R_LSB 20
`define PHC_FAST_BIT 23
`define PHC_L2P_MSB 26
`define PHC_L2P_LSB 24
`define PHC_RBLVL_BIT 21
`define PHC_RBADDR_MSB 20
`define PHC_RBADDR_LSB 16
// ----------------------------------------------------------------------
// Reset words, highest slot first, and fixed codes.
// ----------------------------------------------------------------------
`define PHC_RST_WORDS {32'h001F_0000, 32'h0200_0600, 32'h0780_0600, \
    32'h0040_3000, 32'h1000_1800, 32'h0C08_0000, 32'h0101_0000, \
    32'h0000_00C0, 32'h0000_0000, 32'h8000_8000, 32'h1200_0000}
`define PHC_DAC_MID 10'h200
`define PHC_TUNE_MAX 10'h3FF
`define PHC_MODE_HOLD_EN 2'h2
`endif

// [phc_pkg.sv]
/*
 Types shared by the bank and its two helpers.
 Assumes phc_map.svh is on the include path.
*/
`include "phc_map.svh"
package phc_pkg;
    // Holdover state, one-hot.
    typedef enum logic [1:0] {PHC_TRACK = 2'b01, PHC_HOLD = 2'b10}
        phc_hold_t;
    // Divider and window settings handed to the loops.
    typedef struct packed {
        logic [1:0] loop1Window;
        logic [1:0] loop2Window;
        logic [1:0] input0Predivide;
        logic [1:0] input1Predivide;
        logic [13:0] loop1RefDiv;
        logic [13:0] loop1FbDiv;
        logic [11:0] loop2RefDiv;
        logic [17:0] loop2FbDiv;
        logic [2:0] loop2Prescaler;
        logic refDoubler;
        logic fastDetector;
    } phc_cfg_t;
    // Serial port state; sync stages, shifters and strobes.
    typedef struct packed {
        logic clkS1, clkS2, clkS3;
        logic datS1, datS2;
        logic leS1, leS2, leS3;
        logic [31:0] shIn;
        logic [31:0] shOut;
        logic loadPend;
        logic valid;
    } phc_ser_t;
    // Lock qualifier state.
    typedef struct packed {
        logic [13:0] count;
        logic locked;
    } phc_lock_t;
endpackage : phc_pkg

// [phc_lock_counter.sv]
/*
 Lock qualifier: counts detector ticks spent inside the window.
 Assumes tick and inWindow come from logic on clk_sys.
*/
`timescale 1ns/1ns
module phc_lock_counter
    import phc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clear,
    input wire logic tick,
    input wire logic inWindow,
    input wire logic [13:0] target,
    output logic locked
);
    phc_lock_t st_r;
    phc_lock_t st_nxt;
    // One miss restarts the run; the count saturates at the target.
    always_comb
    begin
        st_nxt = st_r;
        if (clear)
            st_nxt = '0;
        else if (tick && !inWindow)
            st_nxt = '0;
        else if (tick && st_r.count >= target)
            st_nxt.locked = 1'b1;
        else if (tick)
            st_nxt.count = st_r.count + 14'h0001;
    end
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign locked = st_r.locked;
    a_lock_qualify: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(st_r.locked) |-> $past(st_r.count) == $past(target))
        else $error("Lock asserted before the run reached its count.");
endmodule : phc_lock_counter

// [phc_serial_port.sv]
/*
 Three-wire serial port: 32-bit words in, MSB first, latched on the
 strobe's rising edge; readback word shifted out on serial clock rises.
 Assumes the serial clock is far slower than clk_sys.
*/
`timescale 1ns/1ns
module phc_serial_port
    import phc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic serClk,
    input wire logic serData,
    input wire logic serLatch,
    input wire logic rbLevel,
    input wire logic [31:0] rbWord,
    output logic wordValid,
    output logic [31:0] wordData,
    output logic serReadData
);
    phc_ser_t s_r;
    phc_ser_t s_nxt;
    logic clkRise;
    logic leRise;
    assign clkRise = s_r.clkS2 & ~s_r.clkS3;
    assign leRise = s_r.leS2 & ~s_r.leS3;
    // Pins pass two stages before any edge logic looks at them.
    always_comb
    begin
        s_nxt = s_r;
        {s_nxt.clkS1, s_nxt.clkS2, s_nxt.clkS3} = {serClk, s_r.clkS1,
            s_r.clkS2};
        {s_nxt.datS1, s_nxt.datS2} = {serData, s_r.datS1};
        {s_nxt.leS1, s_nxt.leS2, s_nxt.leS3} = {serLatch, s_r.leS1,
            s_r.leS2};
        s_nxt.valid = leRise;
        s_nxt.loadPend = s_r.valid;
        if (clkRise)
            s_nxt.shIn = {s_r.shIn[30:0], s_r.datS2};
        if (clkRise && s_r.leS2 == rbLevel)
            s_nxt.shOut = {s_r.shOut[30:0], 1'b0};
        // Load a cycle after the write so a new select is already seen.
        if (s_r.loadPend)
            s_nxt.shOut = rbWord;
    end
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
    assign wordValid = s_r.valid;
    assign wordData = s_r.shIn;
    assign serReadData = s_r.shOut[31];
    a_readback_load: assert property (@(posedge clk_sys) disable iff (!nrst)
        leRise |=> ##2 s_r.shOut == $past(rbWord))
        else $error("Readback word not loaded after the latch.");
endmodule : phc_serial_port

// [phc_config_bank.sv]
/*
 Lock-detect, holdover, tuning DAC and divider configuration bank of a
 dual-loop clock conditioner, programmed over a three-wire serial port.
 Assumes detector ticks, window flags, the digitised tuning voltage and
 the holdover mode come from logic on clk_sys; serial pins are async.
*/
`timescale 1ns/1ns
`include "phc_map.svh"
module phc_config_bank
    import phc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic serClk,
    input wire logic serData,
    input wire logic serLatch,
    output logic serReadData,
    input wire logic pd1Tick,
    input wire logic pd2Tick,
    input wire logic loop1InWindow,
    input wire logic loop2InWindow,
    input wire logic [9:0] tuneVoltage,
    input wire logic [1:0] holdoverMode,
    input wire logic calActive,
    output logic loop1Locked,
    output logic loop2Locked,
    output logic lockIndicator,
    output logic holdoverActive,
    output logic [9:0] dacCode,
    output phc_cfg_t cfg
);
    // ------------------------------------------------------------------
    // State of the bank.
    // ------------------------------------------------------------------
    // Everything the bank keeps itself lives in one packed record; lock counts and serial shifters stay in the helpers.
    typedef struct packed {
        logic [10:0][31:0] regs;
        phc_hold_t holdState;
        logic [9:0] dacValue;
        logic [9:0] dacDivCnt;
        logic loop1Prev;
    } phc_bank_t;

    localparam logic [10:0][31:0] RST_WORDS = `PHC_RST_WORDS;

    phc_bank_t st_r;
    phc_bank_t st_nxt;

    // Map an address onto a storage slot; bit 4 flags a hit.
    function automatic logic [4:0] slotOf(input logic [4:0] addr);
        logic [4:0] res;
        res = 5'h00;
        if (addr >= `PHC_ADDR_TRIP && addr <= `PHC_ADDR_XTAL)
            res = {1'b1, 4'(addr - `PHC_ADDR_TRIP)};
        else if (addr >= `PHC_ADDR_LOOPF)
            res = {1'b1, 4'(addr - `PHC_ADDR_LOOPF + 5'h03)};
        return res;
    endfunction : slotOf

    // ------------------------------------------------------------------
    // Field views of the stored words.
    // ------------------------------------------------------------------
    logic [31:0] wTrip, wHold, wLoopf, wDacdiv, wL2pump, wL1ref;
    logic [31:0] wLdiv, wOsc, wL2fb, wRb;
    assign wTrip = st_r.regs[`PHC_SLOT_TRIP];
    assign wHold = st_r.regs[`PHC_SLOT_HOLD];
    assign wLoopf = st_r.regs[`PHC_SLOT_LOOPF];
    assign wDacdiv = st_r.regs[`PHC_SLOT_DACDIV];
    assign wL2pump = st_r.regs[`PHC_SLOT_L2PUMP];
    assign wL1ref = st_r.regs[`PHC_SLOT_L1REF];
    assign wLdiv = st_r.regs[`PHC_SLOT_LDIV];
    assign wOsc = st_r.regs[`PHC_SLOT_OSC];
    assign wL2fb = st_r.regs[`PHC_SLOT_L2FB];
    assign wRb = st_r.regs[`PHC_SLOT_RB];

    logic railEnable; // Rail detect enable.
    logic manualEnable; // Manual tuning override.
    logic forceHold; // Force holdover.
    logic writeLock; // Register write lock.
    logic rbLevel; // Strobe level expected during readback.
    logic [5:0] highTrip;
    logic [5:0] lowTrip;
    logic [9:0] manualValue;
    logic [9:0] dacDivisor;
    logic [4:0] rbAddr;
    assign railEnable = wTrip[`PHC_BIT5];
    assign highTrip = wTrip[`PHC_HITRIP_MSB:`PHC_HITRIP_LSB];
    assign lowTrip = wTrip[`PHC_LOTRIP_MSB:`PHC_LOTRIP_LSB];
    assign manualValue = wHold[`PHC_TOP10_MSB:`PHC_TOP10_LSB];
    assign manualEnable = wHold[`PHC_MANEN_BIT];
    assign forceHold = wHold[`PHC_BIT5];
    assign dacDivisor = wDacdiv[`PHC_TOP10_MSB:`PHC_TOP10_LSB];
    assign writeLock = wRb[`PHC_BIT5];
    assign rbLevel = wRb[`PHC_RBLVL_BIT];
    assign rbAddr = wRb[`PHC_RBADDR_MSB:`PHC_RBADDR_LSB];

    // ------------------------------------------------------------------
    // Serial port and readback mux.
    // ------------------------------------------------------------------
    logic wordValid;
    logic [31:0] wordData;
    logic [31:0] rbWord;
    logic [4:0] rbHit;
    logic [4:0] wrHit;

    assign rbHit = slotOf(rbAddr);
    assign wrHit = slotOf(wordData[4:0]);

    // The manual tuning field reads back the live DAC code, not the
    // value written; unmapped selects read as zero.
    always_comb
    begin
        rbWord = 32'h0000_0000;
        if (rbHit[4])
            rbWord = {st_r.regs[rbHit[3:0]][31:5], rbAddr};
        if (rbHit[4] && rbHit[3:0] == `PHC_SLOT_HOLD)
            rbWord[`PHC_TOP10_MSB:`PHC_TOP10_LSB] = st_r.dacValue;
    end

    phc_serial_port u_port (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .serClk(serClk),
        .serData(serData),
        .serLatch(serLatch),
        .rbLevel(rbLevel),
        .rbWord(rbWord),
        .wordValid(wordValid),
        .wordData(wordData),
        .serReadData(serReadData)
    );

    // ------------------------------------------------------------------
    // Lock qualifiers.
    // ------------------------------------------------------------------
    logic l1Raw;
    logic exitQualified;
    logic railTrip;
    logic railHigh;
    logic railLow;

    // Loop one lock count.
    phc_lock_counter u_lock1 (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clear(1'b0),
        .tick(pd1Tick),
        .inWindow(loop1InWindow),
        .target(wDacdiv[`PHC_CNT14_MSB:`PHC_CNT14_LSB]),
        .locked(l1Raw)
    );

    // Loop two lock count.
    phc_lock_counter u_lock2 (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clear(1'b0),
        .tick(pd2Tick),
        .inWindow(loop2InWindow),
        .target(wL2pump[`PHC_CNT14_MSB:`PHC_CNT14_LSB]),
        .locked(loop2Locked)
    );

    // Exit qualifier restarts each time holdover is entered, so a lock
    // run that began before the loss does not count.
    phc_lock_counter u_exit (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clear(st_r.holdState == PHC_TRACK),
        .tick(pd1Tick),
        .inWindow(loop1InWindow),
        .target(wHold[`PHC_CNT14_MSB:`PHC_CNT14_LSB]),
        .locked(exitQualified)
    );

    // Trip distances are in tuning code steps from either rail.
    assign railHigh = tuneVoltage >= (`PHC_TUNE_MAX - {4'h0, highTrip});
    assign railLow = tuneVoltage <= {4'h0, lowTrip};
    assign railTrip = railEnable && (railHigh || railLow);

    // A rail trip reads as loss of loop one lock.
    assign loop1Locked = l1Raw && !railTrip;
    assign lockIndicator = loop1Locked && loop2Locked;

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    logic dacUpdate;
    logic lockLost;
    assign dacUpdate = pd1Tick && (st_r.dacDivCnt + 10'h001 >= dacDivisor);
    assign lockLost = st_r.loop1Prev && !loop1Locked;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.loop1Prev = loop1Locked;
        // Writes are dropped for unmapped addresses and, while locked,
        // for every register but the readback one.
        if (wordValid && wrHit[4] &&
            (!writeLock || wrHit[3:0] == `PHC_SLOT_RB))
            st_nxt.regs[wrHit[3:0]] = {wordData[31:5], 5'h00};
        // DAC clock: a divisor of zero acts like one.
        if (pd1Tick)
            st_nxt.dacDivCnt = st_r.dacDivCnt + 10'h001;
        if (dacUpdate)
            st_nxt.dacDivCnt = 10'h000;
        // Manual wins; tracking follows the tuning voltage until
        // holdover freezes the code.
        if (dacUpdate && manualEnable)
            st_nxt.dacValue = manualValue;
        else if (dacUpdate && st_r.holdState == PHC_TRACK)
            st_nxt.dacValue = tuneVoltage;
        // Holdover entry and exit.
        unique case (st_r.holdState)
            PHC_TRACK:
            begin
                if (forceHold || railTrip ||
                    (holdoverMode == `PHC_MODE_HOLD_EN && lockLost))
                    st_nxt.holdState = PHC_HOLD;
            end
            PHC_HOLD:
            begin
                if (!forceHold && !railTrip && exitQualified)
                    st_nxt.holdState = PHC_TRACK;
            end
            default:
            begin
                st_nxt.holdState = PHC_HOLD;
            end
        endcase
    end

    // Every field takes its default at reset, before any programming.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r.regs <= RST_WORDS;
            st_r.holdState <= PHC_TRACK;
            st_r.dacValue <= `PHC_DAC_MID;
            st_r.dacDivCnt <= 10'h000;
            st_r.loop1Prev <= 1'b0;
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign holdoverActive = (st_r.holdState == PHC_HOLD);
    assign dacCode = st_r.dacValue;
    assign cfg.loop1Window = wLoopf[`PHC_WIN1_MSB:`PHC_WIN1_LSB];
    assign cfg.loop2Window = wL2pump[`PHC_WIN2_MSB:`PHC_WIN2_LSB];
    assign cfg.input0Predivide = wL1ref[`PHC_PRE0_MSB:`PHC_PRE0_LSB];
    assign cfg.input1Predivide = wL1ref[`PHC_PRE1_MSB:`PHC_PRE1_LSB];
    assign cfg.loop1RefDiv = wL1ref[`PHC_CNT14_MSB:`PHC_CNT14_LSB];
    assign cfg.loop1FbDiv = wLdiv[`PHC_CNT14_MSB:`PHC_CNT14_LSB];
    assign cfg.loop2RefDiv = wLdiv[`PHC_L2R_MSB:`PHC_L2R_LSB];
    // Calibration runs on its own divide, never the operating one.
    assign cfg.loop2FbDiv = calActive ?
        wOsc[`PHC_DIV18_MSB:`PHC_DIV18_LSB] :
        wL2fb[`PHC_DIV18_MSB:`PHC_DIV18_LSB];
    assign cfg.loop2Prescaler = wL2fb[`PHC_L2P_MSB:`PHC_L2P_LSB];
    assign cfg.refDoubler = wL2pump[`PHC_DOUBLER_BIT];
    assign cfg.fastDetector = wOsc[`PHC_FAST_BIT];

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    a_rail_high_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        (railEnable && railHigh) |=> holdoverActive)
        else $error("High rail trip did not hold over.");
    a_rail_low_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        (railEnable && railLow) |-> !loop1Locked ##1 holdoverActive)
        else $error("Low rail trip did not force unlock.");
    a_rail_disarmed: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!railEnable && l1Raw) |-> loop1Locked)
        else $error("Disarmed rail detect masked lock.");
    a_dac_readback: assert property (@(posedge clk_sys) disable iff (!nrst)
        (rbAddr == `PHC_ADDR_TRIP + 5'h01) |->
        rbWord[`PHC_TOP10_MSB:`PHC_TOP10_LSB] == dacCode)
        else $error("Manual field readback is not the DAC code.");
    a_manual_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
        (dacUpdate && manualEnable) |=> dacCode == $past(manualValue))
        else $error("Manual override did not drive the DAC.");
    a_dac_frozen: assert property (@(posedge clk_sys) disable iff (!nrst)
        (holdoverActive && !manualEnable) |=> $stable(dacCode))
        else $error("DAC moved during holdover.");
    a_exit_qualified: assert property (@(posedge clk_sys) disable iff (!nrst)
        $fell(holdoverActive) |-> $past(exitQualified) &&
        !$past(forceHold))
        else $error("Holdover left without a qualified lock.");
    a_force_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        forceHold |=> holdoverActive)
        else $error("Forced holdover not entered.");
    a_loss_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        (holdoverMode == `PHC_MODE_HOLD_EN && lockLost) |=>
        holdoverActive)
        else $error("Lock loss did not enter holdover.");
    a_write_lock: assert property (@(posedge clk_sys) disable iff (!nrst)
        (wordValid && writeLock && wordData[4:0] != `PHC_ADDR_RB) |=>
        st_r.regs == $past(st_r.regs))
        else $error("Locked register changed on a write.");
endmodule : phc_config_bank

// [phc_host_model.sv]
/* Host on the three-wire serial port.
 Assumes clk_sys paces the bits; the strobe stays low for readback. */
`timescale 1ns/1ns
module phc_host_model
(
    input wire logic clk_sys,
    input wire logic serReadData,
    output logic serClk,
    output logic serData,
    output logic serLatch
);
    initial
    begin
        {serClk, serData, serLatch} = 3'h0;
    end
    // Sends a word MSB first and gathers the previous readback word.
    task automatic xfer(input logic [31:0] w, output logic [31:0] rd);
        for (int i = 31; i >= 0; i--)
        begin
            @(negedge clk_sys);
            serData = w[i];
            repeat (10) @(negedge clk_sys);
            rd[i] = serReadData;
            serClk = 1'b1;
            repeat (10) @(negedge clk_sys);
            serClk = 1'b0;
        end
        serLatch = 1'b1;
        repeat (10) @(negedge clk_sys);
        serLatch = 1'b0;
        // No pull on the data line, so it flips once released.
        serData = ~serData;
        repeat (10) @(negedge clk_sys);
    endtask : xfer
endmodule : phc_host_model

// [testbench.sv]
/* Self-checking bench for the configuration bank.
 Assumes the design and the host model are compiled first. */
`timescale 1ns/1ns
module testbench;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic pd1Tick = 1'b0, pd2Tick = 1'b0, calActive = 1'b0;
    logic loop1InWindow = 1'b0, loop2InWindow = 1'b0, lockBit = 1'b0;
    logic [9:0] tuneVoltage = 10'h100, expDac = 10'h200, dacCode;
    logic [1:0] holdoverMode = 2'h2;
    logic serClk, serData, serLatch, serReadData;
    logic loop1Locked, loop2Locked, lockIndicator, holdoverActive;
    logic [31:0] rd;
    logic [31:0] mdl [32];
    phc_pkg::phc_cfg_t cfg;
    int error_cnt = 0, compares = 0, cyc = 0;
    phc_config_bank dut_u (.clk_sys(clk_sys), .nrst(nrst),
        .serClk(serClk), .serData(serData), .serLatch(serLatch),
        .serReadData(serReadData), .pd1Tick(pd1Tick), .pd2Tick(pd2Tick),
        .loop1InWindow(loop1InWindow), .loop2InWindow(loop2InWindow),
        .tuneVoltage(tuneVoltage), .holdoverMode(holdoverMode),
        .calActive(calActive), .loop1Locked(loop1Locked),
        .loop2Locked(loop2Locked), .lockIndicator(lockIndicator),
        .holdoverActive(holdoverActive), .dacCode(dacCode), .cfg(cfg));
    phc_host_model host_u (.clk_sys(clk_sys), .serReadData(serReadData),
        .serClk(serClk), .serData(serData), .serLatch(serLatch));
    always #25 clk_sys = ~clk_sys;
    // A hang counts as a mismatch and closes the run.
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    function automatic logic mapped(input logic [4:0] a);
        return a == 5'h0E || a == 5'h0F || a == 5'h10 || a >= 5'h18;
    endfunction : mapped
    // Model write: unmapped places and locked registers keep their value.
    task automatic wr(input logic [4:0] a, input logic [26:0] d);
        host_u.xfer({d, a}, rd);
        if (mapped(a) && (a == 5'h1F || !mdl[31][5]))
            mdl[a] = {d, 5'h00};
    endtask : wr
    // Selects a register, then shifts it out under an ignored write.
    task automatic rbchk(input logic [4:0] s);
        logic [31:0] e;
        wr(5'h1F, {10'h000, 1'b0, s, 10'h000, lockBit});
        e = mdl[s] | {27'h0, s};
        if (s == 5'h0F)
            e[31:22] = expDac;
        wr(5'h00, 27'h0);
        chk(rd, e);
    endtask : rbchk
    task automatic tick(input int n, input logic w1, input logic w2);
        repeat (n)
        begin
            @(negedge clk_sys);
            {pd1Tick, pd2Tick, loop1InWindow, loop2InWindow} = {2'h3, w1, w2};
            @(negedge clk_sys);
            {pd1Tick, pd2Tick} = 2'h0;
        end
        repeat (3) @(negedge clk_sys);
    endtask : tick
    initial
    begin
        void'($urandom(32'hd800_ed59));
        foreach (mdl[i])
            mdl[i] = 32'h0;
        {mdl[14], mdl[15], mdl[24], mdl[25], mdl[26]} = {32'h1200_0000,
            32'h8000_8000, 32'h0000_00C0, 32'h0101_0000, 32'h0C08_0000};
        {mdl[27], mdl[28], mdl[29], mdl[30], mdl[31]} = {32'h1000_1800,
            32'h0040_3000, 32'h0780_0600, 32'h0200_0600, 32'h001F_0000};
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        chk(cfg.loop1Window, 2'h3);
        chk(dacCode, 10'h200);
        chk(holdoverActive, 1'b0);
        chk(cfg.fastDetector, 1'b1);
        for (int a = 14; a < 31; a++)
            if (mapped(a[4:0]) && a != 15)
            begin
                rbchk(a[4:0]);
                wr(a[4:0], 27'($urandom));
                rbchk(a[4:0]);
            end
        chk(cfg.loop1RefDiv, mdl[27][19:6]);
        chk(cfg.loop1FbDiv, mdl[28][19:6]);
        chk(cfg.loop2RefDiv, mdl[28][31:20]);
        chk(cfg.loop2FbDiv, mdl[30][22:5]);
        chk(cfg.loop2Prescaler, mdl[30][26:24]);
        chk(cfg.input0Predivide, mdl[27][21:20]);
        chk(cfg.input1Predivide, mdl[27][23:22]);
        chk(cfg.loop2Window, mdl[26][31:30]);
        chk(cfg.fastDetector, mdl[29][23]);
        chk(cfg.refDoubler, mdl[26][29]);
        calActive = 1'b1;
        @(negedge clk_sys);
        chk(cfg.loop2FbDiv, mdl[29][22:5]);
        calActive = 1'b0;
        lockBit = 1'b1;
        rbchk(5'h1B);
        wr(5'h1B, 27'($urandom));
        lockBit = 1'b0;
        rbchk(5'h1B);
        wr(5'h0E, 27'h0);
        wr(5'h19, {10'h001, 2'h0, 14'h0003, 1'b0});
        wr(5'h1A, {12'h000, 14'h0004, 1'b0});
        wr(5'h0F, {10'h155, 2'h1, 14'h0002, 1'b0});
        tick(3, 1'b1, 1'b1);
        chk(loop1Locked, 1'b0);
        tick(1, 1'b1, 1'b1);
        chk(loop1Locked, 1'b1);
        chk(loop2Locked, 1'b0);
        tick(1, 1'b1, 1'b1);
        chk(lockIndicator, 1'b1);
        chk(dacCode, 10'h155);
        expDac = 10'h155;
        rbchk(5'h0F);
        tick(1, 1'b0, 1'b1);
        chk(holdoverActive, 1'b1);
        tick(8, 1'b1, 1'b1);
        chk(holdoverActive, 1'b0);
        wr(5'h0F, {10'h155, 2'h1, 14'h0002, 1'b1});
        chk(holdoverActive, 1'b1);
        wr(5'h0F, {10'h155, 2'h1, 14'h0002, 1'b0});
        tick(4, 1'b1, 1'b1);
        chk(holdoverActive, 1'b0);
        tuneVoltage = 10'h003;
        wr(5'h0E, {12'h000, 6'h10, 2'h0, 6'h04, 1'b1});
        chk(loop1Locked, 1'b0);
        chk(holdoverActive, 1'b1);
        tuneVoltage = 10'h3F0;
        @(negedge clk_sys);
        chk(loop1Locked, 1'b0);
        tuneVoltage = 10'h200;
        @(negedge clk_sys);
        chk(loop1Locked, 1'b1);
        // Tracking: frozen while held over, then follows the tuning code.
        wr(5'h0F, {10'h155, 2'h0, 14'h0002, 1'b0});
        tick(3, 1'b1, 1'b1);
        chk(holdoverActive, 1'b0);
        chk(dacCode, 10'h155);
        tick(1, 1'b1, 1'b1);
        chk(dacCode, 10'h200);
        // Without holdover enable a lock loss must not hold over.
        holdoverMode = 2'h0;
        tick(1, 1'b0, 1'b1);
        chk(loop1Locked, 1'b0);
        chk(holdoverActive, 1'b0);
        final_report();
    end
endmodule : testbench
